// ==== tb_vpg_voice_path.sv ====
// Self-checking bench for the voice path control block.
// Assumes the line model drives the converter inputs.
`timescale 1ns/1ns
module tb_vpg_voice_path;
  reg i_core_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg [6:0] i_reg_addr = 7'h00;
  reg [7:0] i_reg_wdata = 8'h00;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  reg i_frame_sync = 1'b0;
  reg [7:0] i_rx_byte = 8'h00;
  reg i_rx_byte_valid = 1'b0;
  reg send = 1'b0;
  reg [15:0] value = 16'h0000;
  wire [7:0] o_reg_rdata, o_tx_byte;
  wire o_reg_rdata_valid, o_tx_byte_valid, o_dac_valid, o_ext_reference_active, adc_valid;
  wire [15:0] o_dac_sample, adc_sample;
  wire [1:0] o_tx_amp_gain, o_rx_amp_gain, o_line_cap_comp;
  wire [2:0] o_impedance_select;
  wire [1:0] outv = {o_tx_byte_valid, o_dac_valid};
  integer miscompares = 0;
  integer compares = 0;
  integer i;
  always #10 i_core_clk = ~i_core_clk;
  vpg_line_model model (.i_core_clk, .i_send(send), .i_value(value),
    .o_adc_sample(adc_sample), .o_adc_valid(adc_valid));
  vpg_voice_path dut (.i_core_clk, .i_resetn, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_reg_rdata_valid, .i_frame_sync, .i_rx_byte,
    .i_rx_byte_valid, .o_tx_byte, .o_tx_byte_valid, .i_adc_sample(adc_sample),
    .i_adc_valid(adc_valid), .o_dac_sample, .o_dac_valid, .o_tx_amp_gain, .o_rx_amp_gain,
    .o_impedance_select, .o_line_cap_comp, .o_ext_reference_active);
  task complete_run;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [95:0] what, input [15:0] exp, input [15:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Strobes drop and the task waits one more cycle, so no strobe is lowered
  // and raised again in the same time step.
  task wr(input [6:0] a, input [7:0] d);
    begin
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_core_clk);
      i_reg_wr = 1'b0;
      @(negedge i_core_clk);
    end
  endtask
  task rd(input [6:0] a, input [7:0] exp);
    begin
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_core_clk);
      i_reg_rd = 1'b0;
      chk("read valid", 16'h1, 16'(o_reg_rdata_valid));
      chk("read data", 16'(exp), 16'(o_reg_rdata));
      @(negedge i_core_clk);
    end
  endtask
  task rx(input [7:0] b, input s);
    begin
      i_rx_byte = b;
      i_frame_sync = s;
      i_rx_byte_valid = 1'b1;
      @(negedge i_core_clk);
      i_rx_byte_valid = 1'b0;
      i_frame_sync = 1'b0;
      @(negedge i_core_clk);
    end
  endtask
  task adc(input [15:0] v);
    begin
      value = v;
      send = 1'b1;
      @(negedge i_core_clk);
      send = 1'b0;
    end
  endtask
  // Waits for a transmit byte (tx high) or a converter sample and compares it.
  task wait_out(input tx, input [15:0] exp);
    integer n;
    begin
      n = 0;
      // A pulse may already stand when the call starts, so look before waiting.
      while (outv[tx] !== 1'b1 && n < 40) begin
        @(negedge i_core_clk);
        n = n + 1;
      end
      if (outv[tx] !== 1'b1) begin
        $display("mismatch output valid expected 1 seen 0");
        miscompares = miscompares + 1;
        complete_run;
      end else begin
        chk(tx ? "tx byte" : "dac sample", exp, tx ? 16'(o_tx_byte) : o_dac_sample);
        @(negedge i_core_clk);
      end
    end
  endtask
  task rx_gain(input [7:0] g, input [7:0] b, input [15:0] exp);
    begin
      wr(7'h0c, g);
      rx(b, 1'b0);
      wait_out(1'b0, exp);
    end
  endtask
  initial begin
    repeat (2) @(negedge i_core_clk);
    i_resetn = 1'b1;
    @(negedge i_core_clk);
    rd(7'h08, 8'h0a);
    rd(7'h0a, 8'h00);
    rd(7'h0b, 8'h03);
    rd(7'h6c, 8'h00);
    rd(7'h10, 8'h00);
    chk("impedance", 16'h0, 16'(o_impedance_select));
    chk("cap comp", 16'h0, 16'(o_line_cap_comp));
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(7'h08, 8'(i * 5));
      chk("tx amp", 16'(i), 16'(o_tx_amp_gain));
      chk("rx amp", 16'(i), 16'(o_rx_amp_gain));
    end
    wr(7'h6c, 8'hff);
    rd(7'h6c, 8'h10);
    for (i = 0; i < 8; i = i + 1) begin
      wr(7'h0a, 8'(8'h30 + i));
      chk("impedance", 16'(i), 16'(o_impedance_select));
      chk("cap comp", 16'h3, 16'(o_line_cap_comp));
      chk("ext ref", 16'(i > 5), 16'(o_ext_reference_active));
    end
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h37);
    wr(7'h10, 8'hff);
    rd(7'h10, 8'h00);
    $display("test settings done");
    rx_gain(8'h40, 8'h80, 16'h7d7c);
    rx_gain(8'h40, 8'h00, 16'h8284);
    rx_gain(8'h00, 8'hef, 16'h0000);
    rx_gain(8'h80, 8'hef, 16'h0108);
    rx_gain(8'h20, 8'hef, 16'h0042);
    rx_gain(8'hff, 8'h80, 16'h7fff);
    wr(7'h0c, 8'h40);
    $display("test receive gain done");
    wr(7'h0b, 8'h13);
    wr(7'h09, 8'h01);
    rx(8'h12, 1'b1);
    rx(8'h34, 1'b0);
    wait_out(1'b0, 16'h1234);
    adc(16'h5678);
    wait_out(1'b1, 16'h0056);
    wait_out(1'b1, 16'h0078);
    wr(7'h0b, 8'h07);
    adc(16'h5678);
    wait_out(1'b1, 16'h0047);
    wait_out(1'b1, 16'h00e5);
    $display("test linear and balance done");
    wr(7'h0b, 8'h13);
    wr(7'h09, 8'h04);
    adc(16'h2468);
    wait_out(1'b0, 16'h2468);
    wr(7'h09, 8'h02);
    adc(16'h7d7c);
    wait_out(1'b1, 16'h0080);
    wait_out(1'b0, 16'h7d7c);
    wr(7'h09, 8'h08);
    rx(8'h80, 1'b0);
    wait_out(1'b1, 16'h0080);
    wr(7'h09, 8'h18);
    rx(8'h7d, 1'b1);
    rx(8'h7c, 1'b0);
    wait_out(1'b1, 16'h007d);
    wait_out(1'b1, 16'h007c);
    wr(7'h0b, 8'h07);
    wr(7'h09, 8'h06);
    rx(8'h80, 1'b0);
    wait_out(1'b0, 16'h7d7c);
    wait_out(1'b1, 16'h0086);
    wr(7'h09, 8'h16);
    rx(8'h7d, 1'b1);
    rx(8'h7c, 1'b0);
    wait_out(1'b1, 16'h0064);
    wait_out(1'b1, 16'h007c);
    $display("test loopbacks done");
    i_resetn = 1'b0;
    @(negedge i_core_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk("impedance", 16'h0, 16'(o_impedance_select));
    chk("tx amp", 16'h2, 16'(o_tx_amp_gain));
    $display("test second reset done");
    complete_run;
  end
endmodule // tb_vpg_voice_path

// ==== vpg_compressor.v ====
// Mu-law compressor: one 16-bit linear sample to an 8-bit code.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ns
`include "vpg_consts.vh"
module vpg_compressor (
  // Linear in
  input wire [15:0] i_sample,
  // Code out
  output wire [7:0] o_code
);
  reg [15:0] mag;
  reg [2:0] expo;
  reg [3:0] mant;
  integer k;
  always @* begin
    mag = i_sample[15] ? (16'h0000 - i_sample) : i_sample;
    if (mag > `VPG_ULAW_CLIP) begin
      mag = `VPG_ULAW_CLIP;
    end
    mag = mag + `VPG_ULAW_BIAS;
    expo = 3'h0;
    for (k = 1; k < 8; k = k + 1) begin
      if (mag[k + 7]) begin
        expo = k[2:0];
      end
    end
    mant = mag[expo + 4'h3 +: 4];
  end
  assign o_code = ~{i_sample[15], expo, mant};
endmodule // vpg_compressor

// ==== vpg_consts.vh ====
// Constants for the voice path gain and loopback control block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef VPG_CONSTS_VH
`define VPG_CONSTS_VH
// Register addresses on the 7-bit control port.
`define VPG_ADDR_AUDIO_GAIN 7'h08
`define VPG_ADDR_PATH_MODE 7'h09
`define VPG_ADDR_LINE_IMP 7'h0a
`define VPG_ADDR_HYBRID 7'h0b
`define VPG_ADDR_RX_DGAIN 7'h0c
`define VPG_ADDR_EXT_REF 7'h6c
// Reset values.
`define VPG_RST_AUDIO_GAIN 8'h0a
`define VPG_RST_PATH_MODE 8'h00
`define VPG_RST_LINE_IMP 8'h00
`define VPG_RST_HYBRID 8'h03
`define VPG_RST_RX_DGAIN 8'h40
`define VPG_RST_EXT_REF 8'h00
// Field positions.
`define VPG_TXAMP_LSB 0
`define VPG_RXAMP_LSB 2
`define VPG_LINFMT_BIT 0
`define VPG_LOOP_LSB 1
`define VPG_CBYP_BIT 4
`define VPG_IMPSEL_LSB 0
`define VPG_CLC_LSB 4
`define VPG_BAL_LSB 0
`define VPG_HYBOFF_BIT 4
`define VPG_EXTREF_BIT 4
// Field masks for readback.
`define VPG_MASK_AUDIO_GAIN 8'h0f
`define VPG_MASK_PATH_MODE 8'h1f
`define VPG_MASK_LINE_IMP 8'h37
`define VPG_MASK_HYBRID 8'h17
`define VPG_MASK_EXT_REF 8'h10
// Analog amplifier gain codes.
`define VPG_AMP_MUTE 2'h0
`define VPG_AMP_M3P5 2'h1
`define VPG_AMP_0DB 2'h2
`define VPG_AMP_P3P5 2'h3
// Loopback mode codes.
`define VPG_LOOP_NONE 3'h0
`define VPG_LOOP_FULL_ANA 3'h1
`define VPG_LOOP_PART_ANA 3'h2
`define VPG_LOOP_FULL_DIG 3'h3
`define VPG_LOOP_PART_DIG 3'h4
// Impedance settings: code 0 is 600 ohm, 6 and 7 are the complex ones.
`define VPG_IMP_600 3'h0
`define VPG_IMP_CPLX_A 3'h6
`define VPG_IMP_CPLX_B 3'h7
// Receive digital gain unity point (Q6), full scale is +6 dB.
`define VPG_DGAIN_SHIFT 4'h6
`define VPG_DGAIN_MAX 9'h080
// Balance coefficients (Q8), -8.77 dB up to -1.92 dB.
`define VPG_BAL_SHIFT 4'h8
`define VPG_BAL0 9'h05d
`define VPG_BAL1 9'h068
`define VPG_BAL2 9'h075
`define VPG_BAL3 9'h083
`define VPG_BAL4 9'h092
`define VPG_BAL5 9'h0a4
`define VPG_BAL6 9'h0b7
`define VPG_BAL7 9'h0cd
// Companding constants.
`define VPG_ULAW_BIAS 16'h0084
`define VPG_ULAW_CLIP 16'h7f7b
`endif

// ==== vpg_expander.v ====
// Mu-law expander: one 8-bit code to a 16-bit linear sample.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ns
`include "vpg_consts.vh"
module vpg_expander (
  // Code in
  input wire [7:0] i_code,
  // Linear out
  output wire [15:0] o_sample
);
  wire [7:0] inv;
  wire [15:0] mag;
  assign inv = ~i_code;
  assign mag = (({8'h00, 1'b1, inv[3:0], 3'h0} + `VPG_ULAW_BIAS - 16'h0080)
    << inv[6:4]) - `VPG_ULAW_BIAS;
  assign o_sample = inv[7] ? (16'h0000 - mag) : mag;
endmodule // vpg_expander

// ==== vpg_line_model.sv ====
// Model of the converter side that supplies transmit samples.
// Assumes the bench asks for one sample by raising i_send for one cycle.
`timescale 1ns/1ns
module vpg_line_model (
  // Clock and request
  input wire i_core_clk,
  input wire i_send,
  input wire [15:0] i_value,
  // Converter outputs
  output reg [15:0] o_adc_sample,
  output reg o_adc_valid
);
  reg pend = 1'b0;
  initial o_adc_sample = 16'h0000;
  initial o_adc_valid = 1'b0;
  always @(posedge i_core_clk) pend <= i_send;
  // Between samples the data toggles, so a stale word is never taken as new.
  always @(negedge i_core_clk) begin
    o_adc_valid <= pend;
    o_adc_sample <= pend ? i_value : ~o_adc_sample;
  end
endmodule // vpg_line_model

// ==== vpg_voice_path.v ====
// Voice path control: gains, transhybrid balance, loopbacks, line setup.
// Assumes one 50 MHz clock; sample strobes are one-cycle pulses at 8 kHz.
// What this block does
// - Expand each received compressed 8-bit code into a 16-bit linear sample.
// - With linear format set, join two received bytes into one 16-bit sample.
// - Scale received samples by digital gain from full mute to +6 dB.
// - Transmit analog amplifier gain selects mute, -3.5, 0 or +3.5 dB.
// - Transmit converter supplies 16-bit linear samples at 8 kHz.
// - Receive analog amplifier gain selects mute, -3.5, 0 or +3.5 dB.
// - Three-bit balance field sets cancellation gain -8.77 to -1.92 dB.
// - Subtract cancellation term before any transmit gain stage.
// - A register bit switches transhybrid cancellation off entirely.
// - Full analog loopback feeds compressed transmit bytes into the expander.
// - Partial analog loopback sends converter samples straight to receive converter.
// - Full digital loopback returns receive output to transmit via hybrid path.
// - Partial digital loopback sends receive converter input into transmit filter.
// - Digital loopbacks may bypass companding and carry 16-bit linear words.
// - Three-bit field selects one of eight line impedance settings.
// - Without a write, the impedance setting is 600 ohm.
// - Line capacitance boost field defaults to no line capacitance.
// - Bit 4 of register 108 selects external reference for complex settings.
`timescale 1ns/1ns
`include "vpg_consts.vh"
module vpg_voice_path (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // Register port
  input wire [6:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rdata_valid,
  // PCM side
  input wire i_frame_sync,
  input wire [7:0] i_rx_byte,
  input wire i_rx_byte_valid,
  output reg [7:0] o_tx_byte,
  output reg o_tx_byte_valid,
  // Converter side
  input wire [15:0] i_adc_sample,
  input wire i_adc_valid,
  output reg [15:0] o_dac_sample,
  output reg o_dac_valid,
  // Analog settings
  output reg [1:0] o_tx_amp_gain,
  output reg [1:0] o_rx_amp_gain,
  output reg [2:0] o_impedance_select,
  output reg [1:0] o_line_cap_comp,
  output reg o_ext_reference_active
);
  localparam TX_IDLE = 1'b0;
  localparam TX_LOW = 1'b1;

  // Saturate a wide signed value to 16 bits.
  function [15:0] vpg_sat;
    input [24:0] v;
    begin
      if (!v[24] && (v[23:15] != 9'h000)) begin
        vpg_sat = 16'h7fff;
      end else if (v[24] && (v[23:15] != 9'h1ff)) begin
        vpg_sat = 16'h8000;
      end else begin
        vpg_sat = v[15:0];
      end
    end
  endfunction

  // Signed 16 by unsigned 9 product, arithmetically shifted.
  function [24:0] vpg_scale;
    input [15:0] s;
    input [8:0] g;
    input [3:0] sh;
    reg signed [24:0] p;
    begin
      p = $signed({{9{s[15]}}, s}) * $signed({16'h0000, g});
      vpg_scale = p >>> sh;
    end
  endfunction

  reg [7:0] audio_gain;
  reg [7:0] path_mode;
  reg [7:0] line_impedance_synthesis_control;
  reg [7:0] hybrid_balance_control;
  reg [7:0] rx_digital_gain;
  reg [7:0] external_reference_option;
  reg rx_phase;
  reg [7:0] rx_high;
  reg [15:0] rx_word;
  reg rx_word_valid;
  reg [15:0] tx_word;
  reg tx_word_valid;
  reg tx_state;
  reg [7:0] tx_low;
  reg [7:0] next_rdata;
  reg [8:0] bal_coef;
  reg [8:0] dgain;

  wire [2:0] loop_mode;
  wire linear_format_select;
  wire comp_bypass;
  wire dig_loop;
  wire full_analog_loopback;
  wire partial_analog_loopback;
  wire full_digital_loopback;
  wire partial_digital_loopback;
  wire hybrid_off;
  wire rx_linear;
  wire [7:0] rx_src_byte;
  wire rx_src_valid;
  wire [15:0] expanded;
  wire [15:0] rx_scaled;
  wire [15:0] hyb_term;
  wire [15:0] tx_code_in;
  wire [7:0] tx_code;
  wire [2:0] impedance_select_field;
  wire [2:0] balance_gain_field;

  assign loop_mode = path_mode[`VPG_LOOP_LSB +: 3];
  assign linear_format_select = path_mode[`VPG_LINFMT_BIT];
  assign comp_bypass = path_mode[`VPG_CBYP_BIT];
  assign full_analog_loopback = (loop_mode == `VPG_LOOP_FULL_ANA);
  assign partial_analog_loopback = (loop_mode == `VPG_LOOP_PART_ANA);
  assign full_digital_loopback = (loop_mode == `VPG_LOOP_FULL_DIG);
  assign partial_digital_loopback = (loop_mode == `VPG_LOOP_PART_DIG);
  assign dig_loop = full_digital_loopback | partial_digital_loopback;
  // Companding is skipped in both digital loopbacks when bypass is set.
  assign rx_linear = linear_format_select | (dig_loop & comp_bypass);
  assign hybrid_off = hybrid_balance_control[`VPG_HYBOFF_BIT];
  assign impedance_select_field = line_impedance_synthesis_control[`VPG_IMPSEL_LSB +: 3];
  assign balance_gain_field = hybrid_balance_control[`VPG_BAL_LSB +: 3];

  // The compressed transmit stream replaces the received stream.
  assign rx_src_byte = full_analog_loopback ? o_tx_byte : i_rx_byte;
  assign rx_src_valid = full_analog_loopback ? o_tx_byte_valid : i_rx_byte_valid;

  vpg_expander u_expander (
    .i_code(rx_src_byte),
    .o_sample(expanded)
  );

  vpg_compressor u_compressor (
    .i_sample(tx_word),
    .o_code(tx_code)
  );

  // Gain above +6 dB is clamped so a stray code cannot overdrive the line.
  always @* begin
    dgain = {1'b0, rx_digital_gain};
    if (dgain > `VPG_DGAIN_MAX) begin
      dgain = `VPG_DGAIN_MAX;
    end
  end
  assign rx_scaled = vpg_sat(vpg_scale(rx_word, dgain, `VPG_DGAIN_SHIFT));

  always @* begin
    case (balance_gain_field)
      3'h0: bal_coef = `VPG_BAL0;
      3'h1: bal_coef = `VPG_BAL1;
      3'h2: bal_coef = `VPG_BAL2;
      3'h3: bal_coef = `VPG_BAL3;
      3'h4: bal_coef = `VPG_BAL4;
      3'h5: bal_coef = `VPG_BAL5;
      3'h6: bal_coef = `VPG_BAL6;
      default: bal_coef = `VPG_BAL7;
    endcase
  end
  // Balance estimate from what is being sent to the line.
  assign hyb_term = vpg_sat(vpg_scale(o_dac_sample, bal_coef, `VPG_BAL_SHIFT));
  assign tx_code_in = tx_word;

  // Register writes.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      audio_gain <= `VPG_RST_AUDIO_GAIN;
      path_mode <= `VPG_RST_PATH_MODE;
      line_impedance_synthesis_control <= `VPG_RST_LINE_IMP;
      hybrid_balance_control <= `VPG_RST_HYBRID;
      rx_digital_gain <= `VPG_RST_RX_DGAIN;
      external_reference_option <= `VPG_RST_EXT_REF;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `VPG_ADDR_AUDIO_GAIN: audio_gain <= i_reg_wdata & `VPG_MASK_AUDIO_GAIN;
        `VPG_ADDR_PATH_MODE: path_mode <= i_reg_wdata & `VPG_MASK_PATH_MODE;
        `VPG_ADDR_LINE_IMP: begin
          line_impedance_synthesis_control <= i_reg_wdata & `VPG_MASK_LINE_IMP;
        end
        `VPG_ADDR_HYBRID: hybrid_balance_control <= i_reg_wdata & `VPG_MASK_HYBRID;
        `VPG_ADDR_RX_DGAIN: rx_digital_gain <= i_reg_wdata;
        `VPG_ADDR_EXT_REF: begin
          external_reference_option <= i_reg_wdata & `VPG_MASK_EXT_REF;
        end
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses answer zero.
  always @* begin
    case (i_reg_addr)
      `VPG_ADDR_AUDIO_GAIN: next_rdata = audio_gain;
      `VPG_ADDR_PATH_MODE: next_rdata = path_mode;
      `VPG_ADDR_LINE_IMP: next_rdata = line_impedance_synthesis_control;
      `VPG_ADDR_HYBRID: next_rdata = hybrid_balance_control;
      `VPG_ADDR_RX_DGAIN: next_rdata = rx_digital_gain;
      `VPG_ADDR_EXT_REF: next_rdata = external_reference_option;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
      o_reg_rdata_valid <= 1'b0;
      o_tx_amp_gain <= 2'h0;
      o_rx_amp_gain <= 2'h0;
      o_impedance_select <= `VPG_IMP_600;
      o_line_cap_comp <= 2'h0;
      o_ext_reference_active <= 1'b0;
    end else begin
      o_reg_rdata_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
      o_tx_amp_gain <= audio_gain[`VPG_TXAMP_LSB +: 2];
      o_rx_amp_gain <= audio_gain[`VPG_RXAMP_LSB +: 2];
      o_impedance_select <= impedance_select_field;
      o_line_cap_comp <= line_impedance_synthesis_control[`VPG_CLC_LSB +: 2];
      // The external reference only matters for the two complex settings.
      o_ext_reference_active <= external_reference_option[`VPG_EXTREF_BIT] &
        ((impedance_select_field == `VPG_IMP_CPLX_A) |
         (impedance_select_field == `VPG_IMP_CPLX_B));
    end
  end

  // Receive assembly: expand, or pair high byte then low byte.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_phase <= 1'b0;
      rx_high <= 8'h00;
      rx_word <= 16'h0000;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (rx_src_valid) begin
        if (rx_linear) begin
          // A frame sync in the same cycle restarts the pair on this byte.
          if (!rx_phase || i_frame_sync) begin
            rx_high <= rx_src_byte;
            rx_phase <= 1'b1;
          end else begin
            rx_word <= {rx_high, rx_src_byte};
            rx_word_valid <= 1'b1;
            rx_phase <= 1'b0;
          end
        end else begin
          rx_word <= expanded;
          rx_word_valid <= 1'b1;
          rx_phase <= 1'b0;
        end
      end else if (i_frame_sync) begin
        rx_phase <= 1'b0;
      end
    end
  end

  // Receive converter feed.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dac_sample <= 16'h0000;
      o_dac_valid <= 1'b0;
    end else if (partial_analog_loopback) begin
      o_dac_valid <= i_adc_valid;
      if (i_adc_valid) begin
        o_dac_sample <= i_adc_sample;
      end
    end else begin
      o_dac_valid <= rx_word_valid;
      if (rx_word_valid) begin
        o_dac_sample <= rx_scaled;
      end
    end
  end

  // Transmit sample selection and transhybrid subtraction.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_word <= 16'h0000;
      tx_word_valid <= 1'b0;
    end else if (partial_digital_loopback) begin
      tx_word_valid <= rx_word_valid;
      if (rx_word_valid) begin
        tx_word <= rx_scaled;
      end
    end else if (full_digital_loopback) begin
      tx_word_valid <= o_dac_valid;
      if (o_dac_valid) begin
        tx_word <= hyb_term;
      end
    end else begin
      tx_word_valid <= i_adc_valid;
      if (i_adc_valid) begin
        // Cancellation comes first so later gain changes keep the balance.
        if (hybrid_off) begin
          tx_word <= i_adc_sample;
        end else begin
          tx_word <= vpg_sat({{9{i_adc_sample[15]}}, i_adc_sample} -
            {{9{hyb_term[15]}}, hyb_term});
        end
      end
    end
  end

  // Transmit byte output: one code, or high then low byte when linear.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state <= TX_IDLE;
      tx_low <= 8'h00;
      o_tx_byte <= 8'h00;
      o_tx_byte_valid <= 1'b0;
    end else begin
      o_tx_byte_valid <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (tx_word_valid) begin
            o_tx_byte_valid <= 1'b1;
            if (rx_linear) begin
              o_tx_byte <= tx_code_in[15:8];
              tx_low <= tx_code_in[7:0];
              tx_state <= TX_LOW;
            end else begin
              o_tx_byte <= tx_code;
            end
          end
        end
        TX_LOW: begin
          o_tx_byte <= tx_low;
          o_tx_byte_valid <= 1'b1;
          tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
endmodule // vpg_voice_path

// ==== vpg_voice_path_assertions.sv ====
// Checker for the voice path block, seeing only its top-level ports.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module vpg_voice_path_assertions (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // Register port
  input wire [6:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] o_reg_rdata,
  input wire o_reg_rdata_valid,
  // Settings
  input wire [1:0] o_tx_amp_gain,
  input wire [1:0] o_rx_amp_gain,
  input wire [2:0] o_impedance_select,
  input wire [1:0] o_line_cap_comp,
  input wire o_ext_reference_active
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire wr_gain = i_reg_wr && i_reg_addr == 7'h08;
  wire wr_imp = i_reg_wr && i_reg_addr == 7'h0a;
  wire mapped = i_reg_addr inside {7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h6c};
  reg [7:0] ext_shadow;
  // A shadow copy lets a read be judged however long after the write it comes.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      ext_shadow <= 8'h00;
    else if (i_reg_wr && i_reg_addr == 7'h6c)
      ext_shadow <= i_reg_wdata & 8'h10;
  end
  read_answer_a: assert property (i_reg_rd |=> o_reg_rdata_valid)
    else $error("read answer missing");
  read_quiet_a: assert property (!i_reg_rd |=> !o_reg_rdata_valid && $stable(o_reg_rdata))
    else $error("read output moved without a read");
  unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  amp_gain_follow_a: assert property (wr_gain ##1 !wr_gain |=>
    {o_rx_amp_gain, o_tx_amp_gain} == $past(i_reg_wdata[3:0], 2))
    else $error("amplifier gains do not follow the write");
  impedance_follow_a: assert property (wr_imp ##1 !wr_imp |=>
    {o_line_cap_comp, o_impedance_select} ==
    {$past(i_reg_wdata[5:4], 2), $past(i_reg_wdata[2:0], 2)})
    else $error("impedance settings do not follow the write");
  ext_complex_a: assert property (o_ext_reference_active |-> o_impedance_select[2:1] == 2'h3)
    else $error("external reference outside complex settings");
  ext_readback_a: assert property (i_reg_rd && i_reg_addr == 7'h6c |=>
    o_reg_rdata == $past(ext_shadow))
    else $error("reference option readback wrong");
  hybrid_mask_a: assert property (i_reg_rd && i_reg_addr == 7'h0b |=>
    (o_reg_rdata & 8'he8) == 8'h00)
    else $error("hybrid control reserved bits set");
  reset_settings_a: assert property ($rose(i_resetn) |=> o_tx_amp_gain == 2'h2 &&
    o_rx_amp_gain == 2'h2 && o_impedance_select == 3'h0 && o_line_cap_comp == 2'h0)
    else $error("settings wrong after reset");
endmodule // vpg_voice_path_assertions
bind vpg_voice_path vpg_voice_path_assertions chk (.i_core_clk, .i_resetn, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rdata_valid, .o_tx_amp_gain,
  .o_rx_amp_gain, .o_impedance_select, .o_line_cap_comp, .o_ext_reference_active);
